// file: core/idle_cmd_consts.svh
// constants for the idle power command handler
//
// Behaviour
// - idle command decodes from two opcodes; sector count carries the timeout code
// - idle in standby enters performance idle, loads timer, starts countdown
// - idle command while already idle keeps the current idle mode
// - entering idle spins up the spindle unless already rotating
// - timeout code zero disables auto power-down; non-zero enables it
// - codes 1-240 give value times five; 241-251 give half hours
// - codes 252 to 255 give the four fixed special intervals
// - with auto power-down on, timer expiry without access enters standby
// - any host access before expiry reloads the full interval
// - idle-immediate decodes from two opcodes and takes no parameters
// - idle-immediate enters performance idle and spins up if not rotating
// - idle-immediate leaves the stored timeout code untouched
// - unload is idle-immediate, count zero plus signature; completion returns c4
// - unload request stops any read look-ahead in progress
// - unload while writing suspends cache flushing, keeping cached data
// - flushing resumes on soft reset, hard reset or any non-unload command
`ifndef IDLE_CMD_CONSTS_SVH
`define IDLE_CMD_CONSTS_SVH

`define OP_IDLE_A        8'he3
`define OP_IDLE_B        8'h97
`define OP_IMM_A         8'he1
`define OP_IMM_B         8'h95
`define UNLOAD_COUNT     8'h00
`define UNLOAD_SIG_LOW   8'h4c
`define UNLOAD_SIG_MID   8'h4e
`define UNLOAD_SIG_HIGH  8'h55
`define UNLOAD_ANSWER    8'hc4

`define CODE_LIN_MAX     8'd240
`define CODE_HALF_MAX    8'd251
`define CODE_21M         8'd252
`define CODE_8H          8'd253
`define CODE_21M10       8'd254
`define LIN_STEP_S       32'd5
`define HALF_HOUR_S      32'd1800
`define T_21M_S          15'd1260
`define T_8H_S           15'd28800
`define T_21M10_S        15'd1270
`define T_21M15_S        15'd1275

`define STAT_BSY_BIT     7
`define STAT_RDY_BIT     6
`define STAT_DF_BIT      5
`define STAT_DSC_BIT     4
`define STAT_ERR_BIT     0
`define ERR_ABT_BIT      2
`define STATUS_RESET     8'h00
`define ERROR_RESET      8'h00
`define LBA_LOW_RESET    8'h00
`define TIMEOUT_RESET    8'h00

`define SECOND_NS        1000000000
`define CLOCK_PERIOD_NS  8

`endif

// file: core/idle_cmd_pkg.sv
// types for the idle power command handler
package idle_cmd_pkg;

  typedef enum logic {
    pm_standby,
    pm_idle
  } power_mode_t;

  typedef logic [14:0] seconds_t;

endpackage

// file: core/idle_power_command_handler.sv
// idle and idle-immediate command handling with standby timer and unload
`timescale 1ns/100ps
`include "idle_cmd_consts.svh"
module idle_power_command_handler
  import idle_cmd_pkg::*;
#(
  parameter int TICK_CYCLES = `SECOND_NS / `CLOCK_PERIOD_NS
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  // host command block
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_opcode,
  input  wire logic [7:0] cmd_count,
  input  wire logic [7:0] cmd_lba_low,
  input  wire logic [7:0] cmd_lba_mid,
  input  wire logic [7:0] cmd_lba_high,
  // drive side
  input  wire logic       host_access,
  input  wire logic       soft_reset,
  input  wire logic       spin_fault,
  input  wire logic       writing,
  input  wire logic       lookahead_active,
  input  wire logic       spindle_pin,
  // completion
  output logic            done_q,
  output logic [7:0]      status_q,
  output logic [7:0]      error_q,
  output logic [7:0]      lba_low_out_q,
  // drive state
  output logic            standby_q,
  output logic            spin_up_q,
  output logic            lookahead_stop_q,
  output logic            flush_hold_q,
  output logic            heads_unloaded_q,
  output logic [7:0]      timeout_code_q,
  output logic            timer_enabled_q,
  output seconds_t        remaining_q
);

  // spindle pin synchroniser and settled level
  logic        spin_s1_q;
  logic        spin_s2_q;
  logic        spin_s3_q;
  logic        spinning_q;
  logic        spin_settle;

  // command decode
  logic        op_idle;
  logic        op_imm;
  logic        op_ours;
  logic        sig_match;
  logic        unload_form;
  logic        rejected;
  logic        accept_idle;
  logic        accept_imm;
  logic        accept_unload;
  logic        other_cmd;
  logic        fault_free;

  // power mode
  power_mode_t mode_q;
  power_mode_t mode_d;
  logic        enter_idle;

  // timer control
  logic        tmr_load;
  logic        tmr_restart;
  logic        tmr_run;
  logic        tmr_expire;
  logic        tmr_enabled;
  seconds_t    tmr_remaining;
  logic        any_access;
  logic [7:0]  tmr_code;

  // cache and heads
  logic        flush_set;
  logic        flush_clr;
  logic        stop_pulse;
  logic        heads_set;
  logic        heads_clr;

  // completion fields
  logic [7:0]  status_d;
  logic [7:0]  error_d;
  logic [7:0]  lba_low_d;
  logic        spin_up_d;
  logic        standby_d;
  logic        complete;
  logic        flush_hold_d;
  logic        heads_d;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      spin_s1_q <= 1'b0;
    end else begin
      spin_s1_q <= spindle_pin;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      spin_s2_q <= 1'b0;
    end else begin
      spin_s2_q <= spin_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      spin_s3_q <= 1'b0;
    end else begin
      spin_s3_q <= spin_s2_q;
    end
  end

  // only the later two stages are compared, the first only feeds the second stage
  assign spin_settle = (spin_s2_q == spin_s3_q);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      spinning_q <= 1'b0;
    end else if (spin_settle) begin
      spinning_q <= spin_s3_q;
    end
  end

  // both command families arrive under either of two opcodes
  function automatic logic opcode_pair(input logic [7:0] op,
                                       input logic [7:0] first,
                                       input logic [7:0] second);
    return (op == first) | (op == second);
  endfunction

  // the unload form needs all three signature bytes at once
  function automatic logic unload_signature(input logic [7:0] lo,
                                            input logic [7:0] mi,
                                            input logic [7:0] hi);
    logic lo_ok;
    logic mi_ok;
    logic hi_ok;
    lo_ok = (lo == `UNLOAD_SIG_LOW);
    mi_ok = (mi == `UNLOAD_SIG_MID);
    hi_ok = (hi == `UNLOAD_SIG_HIGH);
    return lo_ok & mi_ok & hi_ok;
  endfunction

  // set beats clear so a request landing with a clear is never lost
  function automatic logic set_clear(input logic cur,
                                     input logic set_in,
                                     input logic clr_in);
    logic nxt;
    nxt = cur;
    if (set_in)
      nxt = 1'b1;
    else if (clr_in)
      nxt = 1'b0;
    return nxt;
  endfunction

  assign op_idle = opcode_pair(cmd_opcode, `OP_IDLE_A, `OP_IDLE_B);
  assign op_imm  = opcode_pair(cmd_opcode, `OP_IMM_A, `OP_IMM_B);
  assign op_ours = op_idle | op_imm;

  assign sig_match = unload_signature(cmd_lba_low, cmd_lba_mid, cmd_lba_high);

  assign unload_form = op_imm & (cmd_count == `UNLOAD_COUNT) & sig_match;

  // a spindle that cannot turn makes either command fail
  assign rejected = cmd_valid & op_ours & spin_fault;

  assign fault_free    = ~spin_fault;
  assign accept_idle   = cmd_valid & op_idle & fault_free;
  assign accept_imm    = cmd_valid & op_imm & fault_free;
  assign accept_unload = accept_imm & unload_form;

  // everything except an unload, ours or not, lets the cache drain again
  assign other_cmd = cmd_valid & ~(op_imm & unload_form);

  assign enter_idle = accept_idle | accept_imm;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      pm_standby: begin
        if (enter_idle) begin
          mode_d = pm_idle;
        end
      end
      pm_idle: begin
        if (enter_idle) begin
          mode_d = pm_idle;
        end else if (tmr_expire) begin
          mode_d = pm_standby;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= pm_idle;
    end else begin
      mode_q <= mode_d;
    end
  end

  // stored code changes only on the idle command, never on idle-immediate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timeout_code_q <= `TIMEOUT_RESET;
    end else if (accept_idle) begin
      timeout_code_q <= cmd_count;
    end
  end

  assign any_access  = host_access | cmd_valid;
  assign tmr_load    = accept_idle;
  assign tmr_restart = any_access & ~accept_idle;
  assign tmr_run     = (mode_q == pm_idle) | accept_idle;
  assign tmr_code    = accept_idle ? cmd_count : timeout_code_q;

  standby_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock       (clock),
    .rstn        (rstn),
    .load        (tmr_load),
    .restart     (tmr_restart),
    .run         (tmr_run),
    .code        (tmr_code),
    .expire_q    (tmr_expire),
    .enabled_q   (tmr_enabled),
    .remaining_q (tmr_remaining)
  );

  assign timer_enabled_q = tmr_enabled;
  assign remaining_q     = tmr_remaining;

  // spin request drops by itself once the spindle reports rotation
  assign spin_up_d = (mode_d == pm_idle) & ~spinning_q;

  assign standby_d = (mode_d == pm_standby);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      spin_up_q <= 1'b0;
    end else begin
      spin_up_q <= spin_up_d;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= standby_d;
    end
  end

  assign stop_pulse = accept_unload & lookahead_active;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lookahead_stop_q <= 1'b0;
    end else begin
      lookahead_stop_q <= stop_pulse;
    end
  end

  assign flush_set = accept_unload & writing;
  assign flush_clr = soft_reset | other_cmd;

  // hold only gates the flush; cached data is never dropped here
  assign flush_hold_d = set_clear(flush_hold_q, flush_set, flush_clr);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flush_hold_q <= 1'b0;
    end else begin
      flush_hold_q <= flush_hold_d;
    end
  end

  assign heads_set = accept_unload;
  assign heads_clr = soft_reset | other_cmd;
  assign heads_d   = set_clear(heads_unloaded_q, heads_set, heads_clr);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      heads_unloaded_q <= 1'b0;
    end else begin
      heads_unloaded_q <= heads_d;
    end
  end

  always_comb begin
    status_d = 8'h00;
    status_d[`STAT_BSY_BIT] = 1'b0;
    status_d[`STAT_DF_BIT]  = 1'b0;
    status_d[`STAT_RDY_BIT] = 1'b1;
    status_d[`STAT_DSC_BIT] = 1'b1;
    status_d[`STAT_ERR_BIT] = rejected;
  end

  always_comb begin
    error_d = 8'h00;
    error_d[`ERR_ABT_BIT] = rejected;
  end

  assign lba_low_d = accept_unload ? `UNLOAD_ANSWER : `LBA_LOW_RESET;

  assign complete = cmd_valid & op_ours;

  // completion fields except the one-cycle done_q pulse stand until the next command of ours completes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= complete;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_q <= `STATUS_RESET;
    end else if (complete) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      error_q <= `ERROR_RESET;
    end else if (complete) begin
      error_q <= error_d;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lba_low_out_q <= `LBA_LOW_RESET;
    end else if (complete) begin
      lba_low_out_q <= lba_low_d;
    end
  end

endmodule // idle_power_command_handler

// file: core/standby_timer.sv
// standby countdown timer with timeout code decode
`timescale 1ns/100ps
`include "idle_cmd_consts.svh"
module standby_timer
  import idle_cmd_pkg::*;
#(
  parameter int TICK_CYCLES = `SECOND_NS / `CLOCK_PERIOD_NS
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       load,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic [7:0] code,
  output logic            expire_q,
  output logic            enabled_q,
  output seconds_t        remaining_q
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  function automatic seconds_t decode_code(input logic [7:0] c);
    seconds_t s;
    s = '0;
    if (c == 8'h00)
      s = '0;
    else if (c <= `CODE_LIN_MAX)
      s = seconds_t'(32'(c) * `LIN_STEP_S);
    else if (c <= `CODE_HALF_MAX)
      s = seconds_t'((32'(c) - 32'(`CODE_LIN_MAX)) * `HALF_HOUR_S);
    else if (c == `CODE_21M)
      s = `T_21M_S;
    else if (c == `CODE_8H)
      s = `T_8H_S;
    else if (c == `CODE_21M10)
      s = `T_21M10_S;
    else
      s = `T_21M15_S;
    return s;
  endfunction

  logic [PW-1:0] pre_q;
  logic          tick;
  logic          reload;

  assign reload = load | restart;
  assign tick   = run & enabled_q & (pre_q == PW'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      pre_q <= '0;
    else if (reload || !run || tick)
      pre_q <= '0;
    else
      pre_q <= pre_q + PW'(1);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      enabled_q <= 1'b0;
    else if (load)
      enabled_q <= (code != 8'h00);
  end

  // a reload in the same cycle as the last tick wins, so access never loses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      remaining_q <= '0;
      expire_q    <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (reload)
        remaining_q <= decode_code(code);
      else if (tick && remaining_q != '0) begin
        remaining_q <= remaining_q - seconds_t'(1);
        expire_q    <= (remaining_q == seconds_t'(1));
      end
    end
  end

endmodule // standby_timer

// file: test/host_model.sv
// host controller model issuing commands
`timescale 1ns/100ps
module host_model (
  input  wire logic clock,
  output logic       cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_count,
  output logic [7:0] cmd_lba_low,
  output logic [7:0] cmd_lba_mid,
  output logic [7:0] cmd_lba_high,
  output logic       host_access,
  output logic       soft_reset
);
  initial begin
    {cmd_valid, cmd_opcode, cmd_count, cmd_lba_low, cmd_lba_mid, cmd_lba_high} = '0;
    {host_access, soft_reset} = 2'b00;
  end
  task automatic issue(input logic [7:0] op, cnt, lo, mi, hi);
    @(posedge clock);
    cmd_valid <= 1'b1;
    {cmd_opcode, cmd_count, cmd_lba_low, cmd_lba_mid, cmd_lba_high} <= {op, cnt, lo, mi, hi};
    @(posedge clock);
    cmd_valid <= 1'b0;
    // released fields scramble so stale values never pass
    {cmd_opcode, cmd_count, cmd_lba_low, cmd_lba_mid, cmd_lba_high} <= ~{op, cnt, lo, mi, hi};
  endtask
  task automatic strobe(input logic acc, sr);
    @(posedge clock);
    {host_access, soft_reset} <= {acc, sr};
    @(posedge clock);
    {host_access, soft_reset} <= 2'b00;
  endtask
endmodule // host_model

// file: test/idle_power_command_handler_assertions.sv
// concurrent checks on the idle power command handler ports
`timescale 1ns/100ps
`include "idle_cmd_consts.svh"
module idle_power_command_handler_checker (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_count,
  input wire logic [7:0] cmd_lba_low,
  input wire logic [7:0] cmd_lba_mid,
  input wire logic [7:0] cmd_lba_high,
  input wire logic       soft_reset,
  input wire logic       spin_fault,
  input wire logic       writing,
  input wire logic       lookahead_active,
  input wire logic       done_q,
  input wire logic [7:0] status_q,
  input wire logic [7:0] error_q,
  input wire logic [7:0] lba_low_out_q,
  input wire logic       standby_q,
  input wire logic       lookahead_stop_q,
  input wire logic       flush_hold_q,
  input wire logic       heads_unloaded_q,
  input wire logic [7:0] timeout_code_q,
  input wire logic       timer_enabled_q
);
  wire logic idle = cmd_valid && (cmd_opcode == `OP_IDLE_A || cmd_opcode == `OP_IDLE_B);
  wire logic imm  = cmd_valid && (cmd_opcode == `OP_IMM_A || cmd_opcode == `OP_IMM_B);
  wire logic unl  = imm && cmd_count == `UNLOAD_COUNT && cmd_lba_low == `UNLOAD_SIG_LOW
                    && cmd_lba_mid == `UNLOAD_SIG_MID && cmd_lba_high == `UNLOAD_SIG_HIGH;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_ok; (idle || imm) && !spin_fault; endsequence
  sequence s_unl; unl && !spin_fault; endsequence
  property p_done; idle || imm |=> done_q; endproperty
  property p_other; cmd_valid && !(idle || imm) |=> !done_q; endproperty
  property p_ok; s_ok |=> status_q == 8'h50 && error_q == 8'h00; endproperty
  property p_rej; (idle || imm) && spin_fault |=> status_q == 8'h51 && error_q == 8'h04
    && $stable(timeout_code_q); endproperty
  property p_load; idle && !spin_fault |=> !standby_q && timeout_code_q == $past(cmd_count)
    && timer_enabled_q == ($past(cmd_count) != 8'h00); endproperty
  property p_keep; imm && !spin_fault |=> !standby_q && $stable(timeout_code_q); endproperty
  property p_unl; s_unl |=> lba_low_out_q == `UNLOAD_ANSWER && heads_unloaded_q; endproperty
  property p_stop; s_unl ##0 lookahead_active |=> lookahead_stop_q; endproperty
  property p_hold; s_unl ##0 writing |=> flush_hold_q; endproperty
  property p_resume; flush_hold_q && (soft_reset || cmd_valid) && !unl |=> !flush_hold_q;
  endproperty
  a_done: assert property (p_done) else $error("done missing");
  a_other: assert property (p_other) else $error("done on foreign opcode");
  a_ok: assert property (p_ok) else $error("bad completion status");
  a_rej: assert property (p_rej) else $error("bad abort status");
  a_load: assert property (p_load) else $error("idle load wrong");
  a_keep: assert property (p_keep) else $error("immediate changed code");
  a_unl: assert property (p_unl) else $error("unload answer wrong");
  a_stop: assert property (p_stop) else $error("look-ahead not stopped");
  a_hold: assert property (p_hold) else $error("flush not held");
  a_resume: assert property (p_resume) else $error("flush not resumed");
endmodule // idle_power_command_handler_checker
bind idle_power_command_handler idle_power_command_handler_checker u_chk (.*);

// file: test/idle_power_command_handler_tb_top.sv
// self-checking bench for the idle power command handler
`timescale 1ns/100ps
`include "idle_cmd_consts.svh"
module idle_power_command_handler_tb_top;
  import idle_cmd_pkg::*;
  logic       clock, rstn, cmd_valid, host_access, soft_reset, spin_fault, writing;
  logic       lookahead_active, spindle_pin, done_q, standby_q, spin_up_q, lookahead_stop_q;
  logic       flush_hold_q, heads_unloaded_q, timer_enabled_q;
  logic [7:0] cmd_opcode, cmd_count, cmd_lba_low, cmd_lba_mid, cmd_lba_high;
  logic [7:0] status_q, error_q, lba_low_out_q, timeout_code_q;
  seconds_t   remaining_q;
  int         n_errors = 0;
  int         tests_run = 0;
  typedef struct {logic [7:0] op; logic [7:0] code; logic en; logic [15:0] secs;} row_t;
  row_t rows [9] = '{'{8'he3, 8'h00, 0, 16'h0000}, '{8'h97, 8'h01, 1, 16'h0005},
    '{8'he3, 8'hf0, 1, 16'h04b0}, '{8'h97, 8'hf1, 1, 16'h0708}, '{8'he3, 8'hfb, 1, 16'h4d58},
    '{8'h97, 8'hfc, 1, 16'h04ec}, '{8'he3, 8'hfd, 1, 16'h7080}, '{8'h97, 8'hfe, 1, 16'h04f6},
    '{8'he3, 8'hff, 1, 16'h04fb}};
  // a short second keeps the five-second standby waits of code 1 within the 30-cycle wait limit
  idle_power_command_handler #(.TICK_CYCLES(2)) dut (.*);
  host_model host (.*);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_standby;
    for (int i = 0; i < 30 && standby_q !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check("standby wait", 1, standby_q);
    if (standby_q !== 1'b1) end_of_test();
  endtask
  task automatic unload;
    host.issue(`OP_IMM_A, `UNLOAD_COUNT, `UNLOAD_SIG_LOW, `UNLOAD_SIG_MID, `UNLOAD_SIG_HIGH);
    #1;
  endtask
  initial begin
    {rstn, spin_fault, writing, lookahead_active, spindle_pin} = '0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    #1;
    check("reset standby", 0, standby_q);
    check("reset code", 0, timeout_code_q);
    $display("reset test done");
    foreach (rows[i]) begin
      host.issue(rows[i].op, rows[i].code, 8'h00, 8'h00, 8'h00);
      #1;
      check("done", 1, done_q);
      check("code", rows[i].code, timeout_code_q);
      check("enabled", rows[i].en, timer_enabled_q);
      if (rows[i].en) check("seconds", rows[i].secs, remaining_q);
    end
    $display("code table test done");
    host.issue(`OP_IDLE_B, 8'h01, 8'h00, 8'h00, 8'h00);
    repeat (6) @(posedge clock);
    host.strobe(1'b1, 1'b0);
    repeat (7) @(posedge clock);
    #1;
    check("standby reloaded", 0, standby_q);
    wait_standby();
    host.issue(`OP_IMM_B, 8'h07, 8'h00, 8'h00, 8'h00);
    #1;
    check("imm standby", 0, standby_q);
    check("imm code", 8'h01, timeout_code_q);
    wait_standby();
    host.issue(`OP_IDLE_A, 8'h00, 8'h00, 8'h00, 8'h00);
    repeat (30) @(posedge clock);
    #1;
    check("disabled standby", 0, standby_q);
    check("spin up", 1, spin_up_q);
    $display("timer test done");
    @(posedge clock);
    spin_fault <= 1'b1;
    host.issue(`OP_IDLE_A, 8'h05, 8'h00, 8'h00, 8'h00);
    #1;
    check("abort status", 8'h51, status_q);
    check("abort error", 8'h04, error_q);
    check("abort code", 8'h00, timeout_code_q);
    @(posedge clock);
    {spin_fault, writing, lookahead_active} <= 3'b011;
    unload();
    check("answer", `UNLOAD_ANSWER, lba_low_out_q);
    check("stop", 1, lookahead_stop_q);
    check("hold", 1, flush_hold_q);
    unload();
    check("hold again", 1, flush_hold_q);
    host.issue(8'h20, 8'h00, 8'h00, 8'h00, 8'h00);
    #1;
    check("foreign done", 0, done_q);
    check("hold other", 0, flush_hold_q);
    unload();
    host.strobe(1'b0, 1'b1);
    #1;
    check("hold soft", 0, flush_hold_q);
    unload();
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    #1;
    check("hold hard", 0, flush_hold_q);
    $display("unload test done");
    @(posedge clock);
    spindle_pin <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    check("spinning", 0, spin_up_q);
    $display("spindle test done");
    end_of_test();
  end
endmodule // idle_power_command_handler_tb_top
